/* rtl/can_timing_pkg.sv */
// Constants and types for the CAN bit timing, interrupt identifier and test control block.
// Assumes a 32-bit APB register bus and a single system clock.
package can_timing_pkg;

  // Register byte addresses on the APB bus.
  localparam logic [31:0] ADDR_BIT_TIMING = 32'h4005000C;
  localparam logic [31:0] ADDR_INT_ID     = 32'h40050010;
  localparam logic [31:0] ADDR_TEST       = 32'h40050014;

  // Field positions and widths.
  localparam int BT_WIDTH     = 15;
  localparam int TEST_LSB     = 2;
  localparam int TEST_WIDTH   = 5;
  localparam int TEST_RX_BIT  = 7;
  localparam int NUM_OBJECTS  = 32;

  // Reset values.
  localparam logic [14:0] BT_RESET   = 15'h2301;
  localparam logic [4:0]  TEST_RESET = 5'h00;

  // Interrupt identifier codes.
  localparam logic [15:0] ID_NONE   = 16'h0000;
  localparam logic [15:0] ID_STATUS = 16'h8000;

  // Transmit pin source selections.
  localparam logic [1:0] TX_NORMAL    = 2'h0;
  localparam logic [1:0] TX_SAMPLE    = 2'h1;
  localparam logic [1:0] TX_DOMINANT  = 2'h2;
  localparam logic [1:0] TX_RECESSIVE = 2'h3;

  typedef struct packed {
    logic [2:0] segment_after_sample;
    logic [3:0] segment_before_sample;
    logic [1:0] resync_jump_width;
    logic [5:0] quantum_prescaler;
  } bit_timing_t;

  typedef struct packed {
    logic [1:0] tx_sel;
    logic       loop_back_bit;
    logic       silent;
    logic       basic;
  } test_ctrl_t;

  // Control register bits that live outside this block.
  typedef struct packed {
    logic config_change_enable;
    logic init;
    logic test_enable;
    logic interrupt_enable_bit;
  } ctrl_bits_t;

  typedef enum logic [1:0] {PH_SYNC, PH_SEG1, PH_SEG2} bit_phase_t;

  typedef struct packed {
    bit_timing_t bt;
    test_ctrl_t  test;
    logic        status_pend;
    logic [15:0] int_id;
    logic        irq;
    logic [31:0] prdata;
    logic        rx_meta;
    logic        rx_sync;
    logic [5:0]  pre_cnt;
    logic        tq_tick;
    bit_phase_t  phase;
    logic [4:0]  tq_cnt;
    logic [4:0]  seg_len;
    logic        rx_tq;
    logic        sampled_bit;
    logic        sample_strobe;
    logic        bit_strobe;
    logic        can_tx;
  } state_t;

endpackage

/* rtl/can_timing_irq_test_ctrl.sv */
// CAN bit timing, interrupt identification and test mode control, with its APB register slave.
// Assumes the control register, status register, pending bits and protocol engine sit elsewhere
// on the same clock; only the receive pin comes from outside the clock domain.
//
// Contract
// - Time quantum is system clock divided by 6-bit prescaler plus one.
// - Jump width field at bits 7:6, values 0 to 3, used plus one.
// - Segment before sample point in bits 11:8, values 1 to 15, resets 0011.
// - Segment after sample point in bits 14:12, values 0 to 7, resets 010.
// - Bit timing register resets to 0x2301.
// - Bit timing writes ignored unless config change enable and init both set.
// - Each segment lasts one quantum times field plus one.
// - Resync lengthens or shortens a bit by at most quantum times jump width plus one.
// - Identifier reads zero, object number 1 to 32, or 0x8000 for status.
// - Identifier shows highest priority pending interrupt, whatever the arrival order.
// - Status outranks messages; lower object number has higher priority.
// - Interrupts stay pending until software clears them.
// - Interrupt output high while identifier nonzero and enable bit set.
// - Message interrupt clears when the object pending bit clears.
// - Status interrupt clears when software reads the status register.
// - Test register writable only while test enable is set.
// - Test functions combine; nonzero transmit override disturbs normal transfer.
// - Test bit 2 makes first interface set transmit, second receive buffer.
// - Test bit 3 selects silent mode.
// - Test bit 4 selects loop-back mode.
// - Transmit override bits 6:5 pick normal, sample monitor, dominant or recessive.
// - Test bit 7 reads the inverted receive pin level.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module can_timing_irq_test_ctrl #(
  parameter int OBJECTS = can_timing_pkg::NUM_OBJECTS
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire can_timing_pkg::ctrl_bits_t ctrl,
  input  wire logic                      status_set,
  input  wire logic                      status_read,
  input  wire logic [OBJECTS-1:0]        obj_pending,
  output logic                           irq,
  output logic      [15:0]               interrupt_identifier_field,
  input  wire logic                      core_tx,
  output logic                           core_rx,
  output logic                           sampled_bit,
  output logic                           sample_strobe,
  output logic                           bit_strobe,
  output logic                           basic_mode,
  output logic                           silent_mode,
  output logic                           loop_back_mode,
  output logic                           transfer_disturbed,
  input  wire logic                      can_rx,
  output logic                           can_tx
);

  can_timing_pkg::state_t s_q;
  can_timing_pkg::state_t s_d;

  logic        setup;
  logic        access;
  logic        wr_bt;
  logic        wr_test;
  logic        rx_int;
  logic        edge_seen;
  logic [4:0]  sjw1;
  logic [4:0]  ext;
  logic [4:0]  len_new;
  logic [4:0]  cnt_next;
  logic [4:0]  rem;
  logic        tx_base;

  // Address decode for the error answer; the read mux decodes paddr on its own.
  function automatic logic addr_ok(input logic [31:0] a);
    addr_ok = (a == can_timing_pkg::ADDR_BIT_TIMING) || (a == can_timing_pkg::ADDR_INT_ID) ||
              (a == can_timing_pkg::ADDR_TEST);
  endfunction

  // Fixed priority: status first, then the lowest numbered pending object.
  function automatic logic [15:0] pick_id(input logic st, input logic [OBJECTS-1:0] pend);
    logic [15:0] id;
    id = can_timing_pkg::ID_NONE;
    for (int i = OBJECTS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        id = 16'(i + 1);
      end
    end
    if (st) begin
      id = can_timing_pkg::ID_STATUS;
    end
    return id;
  endfunction

  // Zero wait-state slave; only the three mapped words answer without error.
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign pready  = 1'b1;
  assign pslverr = access & ~addr_ok(paddr);
  assign wr_bt   = access & pwrite & (paddr == can_timing_pkg::ADDR_BIT_TIMING) &
                   ctrl.config_change_enable & ctrl.init;
  assign wr_test = access & pwrite & (paddr == can_timing_pkg::ADDR_TEST) & ctrl.test_enable;

  // The receiver sees its own transmit stream in loop-back, so the bus cannot disturb a self test.
  assign rx_int  = s_q.test.loop_back_bit ? core_tx : s_q.rx_sync;
  assign tx_base = s_q.test.silent ? 1'b1 : core_tx;

  // Resynchronisation arithmetic, evaluated at each quantum tick.
  assign edge_seen = s_q.rx_tq & ~rx_int;
  assign sjw1      = 5'({3'h0, s_q.bt.resync_jump_width}) + 5'h01;
  assign cnt_next  = s_q.tq_cnt + 5'h01;
  assign ext       = (cnt_next < sjw1) ? cnt_next : sjw1;
  assign len_new   = s_q.seg_len + ext;
  assign rem       = s_q.seg_len - s_q.tq_cnt;

  // Next-state logic for the whole block.
  always_comb begin
    s_d = s_q;
    s_d.sample_strobe = 1'b0;
    s_d.bit_strobe    = 1'b0;

    // Receive pin synchroniser.
    s_d.rx_meta = can_rx;
    s_d.rx_sync = s_q.rx_meta;

    // Register writes.
    if (wr_bt) begin
      s_d.bt = can_timing_pkg::bit_timing_t'(pwdata[can_timing_pkg::BT_WIDTH-1:0]);
    end
    if (wr_test) begin
      s_d.test = can_timing_pkg::test_ctrl_t'(pwdata[can_timing_pkg::TEST_LSB +: can_timing_pkg::TEST_WIDTH]);
    end

    // Read data is captured in the setup cycle and stands through the access phase.
    if (setup) begin
      case (paddr)
        can_timing_pkg::ADDR_BIT_TIMING: s_d.prdata = {17'h00000, s_q.bt};
        can_timing_pkg::ADDR_INT_ID:     s_d.prdata = {16'h0000, s_q.int_id};
        can_timing_pkg::ADDR_TEST:       s_d.prdata = {24'h000000, ~s_q.rx_sync, s_q.test, 2'h0};
        default:                         s_d.prdata = 32'h00000000;
      endcase
    end

    // Status pending is sticky; a new event beats a simultaneous read clear.
    s_d.status_pend = status_set | (s_q.status_pend & ~status_read);
    // Object pending bits are held elsewhere, so a cleared bit drops its code on the next clock.
    s_d.int_id = pick_id(s_d.status_pend, obj_pending);
    s_d.irq    = (s_d.int_id != can_timing_pkg::ID_NONE) & ctrl.interrupt_enable_bit;

    // Quantum prescaler: one tick every prescaler plus one clocks.
    if (s_q.pre_cnt >= s_q.bt.quantum_prescaler) begin
      s_d.pre_cnt = 6'h00;
      s_d.tq_tick = 1'b1;
    end else begin
      s_d.pre_cnt = s_q.pre_cnt + 6'h01;
      s_d.tq_tick = 1'b0;
    end

    // Bit phase sequencer, stepping once per quantum.
    if (s_q.tq_tick) begin
      s_d.rx_tq = rx_int;
      case (s_q.phase)
        can_timing_pkg::PH_SYNC: begin
          s_d.phase   = can_timing_pkg::PH_SEG1;
          s_d.tq_cnt  = 5'h00;
          s_d.seg_len = 5'({1'b0, s_q.bt.segment_before_sample}) + 5'h01;
        end
        can_timing_pkg::PH_SEG1: begin
          // A late edge lengthens the first segment.
          if (edge_seen) begin
            s_d.seg_len = len_new;
          end
          if (cnt_next >= (edge_seen ? len_new : s_q.seg_len)) begin
            s_d.phase         = can_timing_pkg::PH_SEG2;
            s_d.tq_cnt        = 5'h00;
            s_d.seg_len       = 5'({2'h0, s_q.bt.segment_after_sample}) + 5'h01;
            s_d.sampled_bit   = rx_int;
            s_d.sample_strobe = 1'b1;
          end else begin
            s_d.tq_cnt = cnt_next;
          end
        end
        can_timing_pkg::PH_SEG2: begin
          // An early edge shortens the second segment; within reach it restarts the bit.
          if (edge_seen && (rem <= sjw1)) begin
            s_d.phase      = can_timing_pkg::PH_SEG1;
            s_d.tq_cnt     = 5'h00;
            s_d.seg_len    = 5'({1'b0, s_q.bt.segment_before_sample}) + 5'h01;
            s_d.bit_strobe = 1'b1;
          end else if (cnt_next >= (edge_seen ? (s_q.seg_len - sjw1) : s_q.seg_len)) begin
            s_d.phase      = can_timing_pkg::PH_SYNC;
            s_d.tq_cnt     = 5'h00;
            s_d.bit_strobe = 1'b1;
          end else begin
            if (edge_seen) begin
              s_d.seg_len = s_q.seg_len - sjw1;
            end
            s_d.tq_cnt = cnt_next;
          end
        end
        default: begin
          s_d.phase  = can_timing_pkg::PH_SYNC;
          s_d.tq_cnt = 5'h00;
        end
      endcase
    end

    // Transmit pin source selection.
    case (s_q.test.tx_sel)
      can_timing_pkg::TX_NORMAL:    s_d.can_tx = tx_base;
      can_timing_pkg::TX_SAMPLE:    s_d.can_tx = s_q.sample_strobe;
      can_timing_pkg::TX_DOMINANT:  s_d.can_tx = 1'b0;
      can_timing_pkg::TX_RECESSIVE: s_d.can_tx = 1'b1;
      default:                      s_d.can_tx = 1'b1;
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q             <= '0;
      s_q.bt          <= can_timing_pkg::BT_RESET;
      s_q.test        <= can_timing_pkg::TEST_RESET;
      s_q.rx_meta     <= 1'b1;
      s_q.rx_sync     <= 1'b1;
      s_q.rx_tq       <= 1'b1;
      s_q.sampled_bit <= 1'b1;
      s_q.can_tx      <= 1'b1;
      s_q.phase       <= can_timing_pkg::PH_SYNC;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs.
  assign prdata                     = s_q.prdata;
  assign irq                        = s_q.irq;
  assign interrupt_identifier_field = s_q.int_id;
  assign core_rx                    = rx_int;
  assign sampled_bit                = s_q.sampled_bit;
  assign sample_strobe              = s_q.sample_strobe;
  assign bit_strobe                 = s_q.bit_strobe;
  assign basic_mode                 = s_q.test.basic;
  assign silent_mode                = s_q.test.silent;
  assign loop_back_mode             = s_q.test.loop_back_bit;
  assign transfer_disturbed         = (s_q.test.tx_sel != can_timing_pkg::TX_NORMAL);
  assign can_tx                     = s_q.can_tx;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_bt_write_blocked;
    access && pwrite && (paddr == can_timing_pkg::ADDR_BIT_TIMING) &&
    !(ctrl.config_change_enable && ctrl.init) |=> $stable(s_q.bt);
  endproperty
  a_bt_write_blocked: assert property (p_bt_write_blocked) else $error("bit timing changed while locked");

  property p_bt_write_taken;
    wr_bt |=> (s_q.bt == $past(pwdata[14:0]));
  endproperty
  a_bt_write_taken: assert property (p_bt_write_taken) else $error("bit timing write lost");

  property p_status_first;
    s_q.status_pend |-> (s_q.int_id == 16'h8000);
  endproperty
  a_status_first: assert property (p_status_first) else $error("status interrupt not shown first");

  property p_object_one;
    !s_q.status_pend && $past(obj_pending[0]) |-> (s_q.int_id == 16'h0001);
  endproperty
  a_object_one: assert property (p_object_one) else $error("object one not given priority");

  property p_irq_follows;
    s_q.irq == ((s_q.int_id != 16'h0000) && $past(ctrl.interrupt_enable_bit));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt line wrong");

  property p_status_held;
    s_q.status_pend && !status_read |=> s_q.status_pend;
  endproperty
  a_status_held: assert property (p_status_held) else $error("status interrupt dropped on its own");

  property p_status_cleared;
    status_read && !status_set |=> !s_q.status_pend;
  endproperty
  a_status_cleared: assert property (p_status_cleared) else $error("status read did not clear");

  property p_test_blocked;
    access && pwrite && (paddr == can_timing_pkg::ADDR_TEST) && !ctrl.test_enable |=> $stable(s_q.test);
  endproperty
  a_test_blocked: assert property (p_test_blocked) else $error("test register changed while disabled");

  property p_tx_dominant;
    (s_q.test.tx_sel == 2'h2) |=> (can_tx == 1'b0);
  endproperty
  a_tx_dominant: assert property (p_tx_dominant) else $error("forced dominant not driven");

  property p_silent_recessive;
    s_q.test.silent && (s_q.test.tx_sel == 2'h0) |=> (can_tx == 1'b1);
  endproperty
  a_silent_recessive: assert property (p_silent_recessive) else $error("silent mode drove dominant");

  property p_tick_spacing;
    s_q.tq_tick && (s_q.bt.quantum_prescaler != 6'h00) && !wr_bt |=> !s_q.tq_tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("quantum ticks too close");

  property p_id_range;
    (s_q.int_id == 16'h0000) || (s_q.int_id == 16'h8000) ||
    ((s_q.int_id >= 16'h0001) && (s_q.int_id <= 16'(OBJECTS)));
  endproperty
  a_id_range: assert property (p_id_range) else $error("identifier holds an unused code");

  property p_status_set_wins;
    status_set |=> s_q.status_pend;
  endproperty
  a_status_set_wins: assert property (p_status_set_wins) else $error("status event lost to a read");

  property p_tx_recessive;
    (s_q.test.tx_sel == 2'h3) |=> (can_tx == 1'b1);
  endproperty
  a_tx_recessive: assert property (p_tx_recessive) else $error("forced recessive not driven");

  property p_tx_normal;
    (s_q.test.tx_sel == 2'h0) && !s_q.test.silent |=> (can_tx == $past(core_tx));
  endproperty
  a_tx_normal: assert property (p_tx_normal) else $error("pin does not follow the controller");

  property p_tx_sample;
    (s_q.test.tx_sel == 2'h1) |=> (can_tx == $past(sample_strobe));
  endproperty
  a_tx_sample: assert property (p_tx_sample) else $error("sample point not shown on the pin");

  property p_loop_back;
    loop_back_mode |-> (core_rx == core_tx);
  endproperty
  a_loop_back: assert property (p_loop_back) else $error("receiver not fed from own stream");

  property p_sample_in_seg2;
    sample_strobe |-> (s_q.phase == can_timing_pkg::PH_SEG2);
  endproperty
  a_sample_in_seg2: assert property (p_sample_in_seg2) else $error("sample point outside segment end");

endmodule

/* sim/can_bus_model.sv */
// Behavioural CAN bus seen from the controller's pins: a wired-AND of our transmit pin and one other node.
// Assumes the bench drives other_dominant on pclk edges; the loop delay is a whole number of clocks.
`timescale 1ns/1ps
module can_bus_model #(
  parameter int DELAY = 2
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic can_tx,
  input  wire logic other_dominant,
  output logic      can_rx
);
  logic       bus_level;
  logic [7:0] line_q;

  // Dominant wins over recessive, so any node pulling low sets the bus level.
  assign bus_level = can_tx & ~other_dominant;

  // The transceiver loop delay is modelled as a short shift line; an idle bus reads recessive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= 8'hFF;
    end else begin
      line_q <= {line_q[6:0], bus_level};
    end
  end

  // A zero delay gives a prompt bus, larger values a slow transceiver.
  assign can_rx = (DELAY == 0) ? bus_level : line_q[DELAY-1];
endmodule

/* sim/tb.sv */
// Self-checking bench for the CAN timing, interrupt identifier and test control block.
// Assumes an APB master on pclk and a bus model for the pins; control and pending bits are driven here.
`timescale 1ns/1ps
module tb;
  logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0]                paddr, pwdata, prdata, d;
  can_timing_pkg::ctrl_bits_t ctrl;
  logic                       status_set, status_read, irq, core_tx, core_rx, sampled_bit;
  logic                       sample_strobe, bit_strobe, basic_mode, silent_mode, loop_back_mode;
  logic                       transfer_disturbed, can_rx, can_tx, other_dominant, e;
  logic [31:0]                obj_pending;
  logic [15:0]                id;
  int                         mismatches, total_checks, n, i;

  can_timing_irq_test_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl(ctrl), .status_set(status_set), .status_read(status_read), .obj_pending(obj_pending), .irq(irq),
    .interrupt_identifier_field(id), .core_tx(core_tx), .core_rx(core_rx), .sampled_bit(sampled_bit),
    .sample_strobe(sample_strobe), .bit_strobe(bit_strobe), .basic_mode(basic_mode),
    .silent_mode(silent_mode), .loop_back_mode(loop_back_mode), .transfer_disturbed(transfer_disturbed),
    .can_rx(can_rx), .can_tx(can_tx));

  can_bus_model #(.DELAY(2)) bus_u (.pclk(pclk), .presetn(presetn), .can_tx(can_tx),
    .other_dominant(other_dominant), .can_rx(can_rx));

  // Clock at 200 MHz.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic step(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // One APB transfer; an idle cycle follows so the next setup never lands in the same time step.
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait-state count is assumed; a slave that never answers is left to the watchdog.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(d, exp);
  endtask

  function automatic logic st(input bit sel);
    return sel ? bit_strobe : sample_strobe;
  endfunction

  // Counts edges until the chosen strobe is seen; strobes are read as they stood before each edge.
  task automatic cnt(input bit sel, output int c);
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (st(sel) !== 1'b1 && c < 400);
    if (st(sel) !== 1'b1) mismatches++; // A strobe that never comes is a failure, not a silent exit.
  endtask

  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial begin
    #100000;
    mismatches++;
    results();
  end

  initial begin
    {presetn, psel, penable, pwrite, status_set, status_read, other_dominant} = '0;
    {paddr, pwdata, obj_pending} = '0;
    ctrl = 4'h0;
    core_tx = 1'b1;
    step(4);
    presetn <= 1'b1;
    step(1);
    rdchk(can_timing_pkg::ADDR_BIT_TIMING, 32'h00002301);
    rdchk(can_timing_pkg::ADDR_INT_ID, 32'h00000000);
    rdchk(can_timing_pkg::ADDR_TEST, 32'h00000000);
    rdchk(32'h40050008, 32'h00000000);
    chk(e, 1'b1);
    // Timing writes land only with both enables; reserved bits stay zero.
    apb(1'b1, can_timing_pkg::ADDR_BIT_TIMING, 32'h00007FFF);
    rdchk(can_timing_pkg::ADDR_BIT_TIMING, 32'h00002301);
    ctrl <= 4'h4;
    apb(1'b1, can_timing_pkg::ADDR_BIT_TIMING, 32'h00007FFF);
    rdchk(can_timing_pkg::ADDR_BIT_TIMING, 32'h00002301);
    ctrl <= 4'hC;
    apb(1'b1, can_timing_pkg::ADDR_BIT_TIMING, 32'hFFFFFFFF);
    rdchk(can_timing_pkg::ADDR_BIT_TIMING, 32'h00007FFF);
    // Prescaler 1, first segment 2, second 1: 6 quanta of 2 clocks per bit.
    apb(1'b1, can_timing_pkg::ADDR_BIT_TIMING, 32'h00001201);
    cnt(1'b1, n);
    cnt(1'b0, n);
    cnt(1'b1, n);
    chk(n, 4);
    cnt(1'b0, n);
    chk(n, 8);
    cnt(1'b1, n);
    cnt(1'b1, n);
    chk(n, 12);
    // The edge reaches the sequencer in the second segment, so that bit loses one quantum.
    // The three idle edges before the count belong to the bit, which lasts 10 clocks instead of 12.
    step(3);
    other_dominant <= 1'b1;
    cnt(1'b1, n);
    chk(n + 3, 10);
    cnt(1'b0, n);
    step(1);
    chk(sampled_bit, 1'b0);
    other_dominant <= 1'b0;
    // Interrupt priority, persistence and clearing.
    ctrl <= 4'h1;
    obj_pending <= 32'h00000024;
    step(2);
    chk(id, 16'h0003);
    chk(irq, 1'b1);
    status_set <= 1'b1;
    step(1);
    status_set <= 1'b0;
    step(20);
    chk(id, 16'h8000);
    rdchk(can_timing_pkg::ADDR_INT_ID, 32'h00008000);
    ctrl <= 4'h0;
    step(2);
    chk(irq, 1'b0);
    ctrl <= 4'h1;
    status_read <= 1'b1;
    step(1);
    status_read <= 1'b0;
    step(2);
    chk(id, 16'h0003);
    chk(irq, 1'b1);
    obj_pending <= 32'h00000020;
    step(2);
    chk(id, 16'h0006);
    obj_pending <= 32'h80000000;
    step(2);
    chk(id, 16'h0020);
    obj_pending <= 32'h00000000;
    step(2);
    chk({irq, id}, 17'h00000);
    // Test register: locked without test enable, then every mode and pin source.
    ctrl <= 4'h0;
    apb(1'b1, can_timing_pkg::ADDR_TEST, 32'h0000007C);
    rdchk(can_timing_pkg::ADDR_TEST, 32'h00000000);
    ctrl <= 4'h2;
    for (i = 0; i < 8; i++) begin
      apb(1'b1, can_timing_pkg::ADDR_TEST, 32'(i) << 2);
      chk({loop_back_mode, silent_mode, basic_mode}, i);
    end
    core_tx <= 1'b0;
    for (i = 0; i < 4; i++) begin
      apb(1'b1, can_timing_pkg::ADDR_TEST, 32'(i) << 5);
      step(2);
      chk(transfer_disturbed, i != 0);
      if (i != 1) begin
        chk(can_tx, i == 3);
      end else begin
        // Sample monitor: the pin pulses high for one clock just after each sample point.
        cnt(1'b0, n);
        step(1);
        chk(can_tx, 1'b1);
        step(1);
        chk(can_tx, 1'b0);
      end
    end
    // Silent mode keeps the pin recessive yet still hears the bus.
    apb(1'b1, can_timing_pkg::ADDR_TEST, 32'h00000008);
    step(2);
    chk(can_tx, 1'b1);
    other_dominant <= 1'b1;
    step(6);
    chk(core_rx, 1'b0);
    rdchk(can_timing_pkg::ADDR_TEST, 32'h00000088);
    other_dominant <= 1'b0;
    step(6);
    rdchk(can_timing_pkg::ADDR_TEST, 32'h00000008);
    // Loop-back hears our own stream, not the other node.
    apb(1'b1, can_timing_pkg::ADDR_TEST, 32'h00000010);
    step(2);
    chk(core_rx, 1'b0);
    core_tx <= 1'b1;
    other_dominant <= 1'b1;
    step(6);
    chk(core_rx, 1'b1);
    other_dominant <= 1'b0;
    results();
  end
endmodule
